// ===== core/dpa_pkg.sv
// constants, types and offsets of the dual product accumulate slice
package dpa_pkg;

    // ----------------------------------------------------------------
    // widths
    // ----------------------------------------------------------------
    localparam int OPW_DEFAULT  = 18;
    localparam int ACCW_DEFAULT = 52;
    localparam int SLICES       = 2;

    // ----------------------------------------------------------------
    // register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [4:0] CTRL_OFFSET      = 5'h00;
    localparam logic [4:0] STATUS_OFFSET    = 5'h04;
    localparam logic [4:0] MASK_OFFSET      = 5'h08;
    localparam logic [4:0] RESULT_LO_OFFSET = 5'h0c;
    localparam logic [4:0] RESULT_HI_OFFSET = 5'h10;

    // ----------------------------------------------------------------
    // fields and reset values
    // ----------------------------------------------------------------
    localparam int CTRL_WIDTH         = 4;
    localparam int CTRL_MODE_BIT      = 0;
    localparam int CTRL_IN_REG_BIT    = 1;
    localparam int CTRL_PIPE_REG_BIT  = 2;
    localparam int CTRL_OUT_REG_BIT   = 3;
    localparam int CTRL_CLEAR_BIT     = 4;
    localparam int STATUS_OVERFLOW_BIT = 0;
    localparam logic [3:0] CTRL_RESET   = 4'h0;
    localparam logic [0:0] STATUS_RESET = 1'h0;
    localparam logic [0:0] MASK_RESET   = 1'h0;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [0:0]
    {
        dual_product_accumulate_mode = 1'b0,
        cascaded_sum_of_products_mode = 1'b1
    } mode_t;

    typedef enum logic [0:0]
    {
        PHASE_IDLE   = 1'b0,
        PHASE_ANSWER = 1'b1
    } bus_phase_t;

endpackage

// ===== core/dual_product_accumulate_slice.sv
// dual product accumulate slice pair with avalon register access
`timescale 1ns/1ps
module dual_product_accumulate_slice #(
    parameter int OPW  = dpa_pkg::OPW_DEFAULT,
    parameter int ACCW = dpa_pkg::ACCW_DEFAULT
) (
    // clock and reset
    input  wire logic                   clock,
    input  wire logic                   rst_b,
    // register bus
    input  wire logic [4:0]             avs_address,
    input  wire logic                   avs_read,
    input  wire logic                   avs_write,
    input  wire logic [31:0]            avs_writedata,
    input  wire logic [3:0]             avs_byteenable,
    output logic [31:0]                 avs_readdata,
    output logic                        avs_waitrequest,
    // interrupt
    output logic                        irq,
    // slice 0 operands
    input  wire logic signed [OPW-1:0]  s0_mult_one_x,
    input  wire logic signed [OPW-1:0]  s0_mult_one_y,
    input  wire logic signed [OPW-1:0]  s0_mult_two_x,
    input  wire logic signed [OPW-1:0]  s0_mult_two_y,
    input  wire logic                   s0_subtract,
    // slice 1 operands
    input  wire logic signed [OPW-1:0]  s1_mult_one_x,
    input  wire logic signed [OPW-1:0]  s1_mult_one_y,
    input  wire logic signed [OPW-1:0]  s1_mult_two_x,
    input  wire logic signed [OPW-1:0]  s1_mult_two_y,
    input  wire logic                   s1_subtract,
    // results
    output logic signed [ACCW-1:0]      result,
    output logic                        overflow
);
    localparam int PW = 2*OPW+1;

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    dpa_pkg::bus_phase_t            phase_reg;
    dpa_pkg::bus_phase_t            phase_next;
    logic [dpa_pkg::CTRL_WIDTH-1:0] ctrl_reg;
    logic [dpa_pkg::CTRL_WIDTH-1:0] ctrl_next;
    logic                           clear_reg;
    logic                           clear_next;
    logic [0:0]                     status_reg;
    logic [0:0]                     status_next;
    logic [0:0]                     mask_reg;
    logic [0:0]                     mask_next;
    logic [31:0]                    readdata_reg;
    logic [31:0]                    readdata_next;
    logic [31:0]                    hi_shadow_reg;
    logic [31:0]                    hi_shadow_next;
    logic signed [ACCW-1:0]         result_reg;
    logic signed [ACCW-1:0]         result_next;
    logic                           overflow_reg;
    logic                           overflow_next;

    wire                     bus_req;
    wire                     taking;
    wire                     wr_take;
    wire                     read_open;
    wire                     sel_ctrl;
    wire                     sel_status;
    wire                     sel_mask;
    wire                     sel_lo;
    wire                     sel_hi;
    wire [31:0]              read_mux;
    wire [63:0]              result_wide;
    wire                     acc_mode;
    wire                     out_bypass;
    wire signed [PW-1:0]     pp [dpa_pkg::SLICES];
    wire signed [ACCW-1:0]   pp_ext [dpa_pkg::SLICES];
    wire signed [ACCW-1:0]   acc_sum;
    wire signed [ACCW-1:0]   cascade_sum;
    wire                     ovf_comb;
    wire                     ovf_set;
    wire signed [OPW-1:0]    op_x1 [dpa_pkg::SLICES];
    wire signed [OPW-1:0]    op_y1 [dpa_pkg::SLICES];
    wire signed [OPW-1:0]    op_x2 [dpa_pkg::SLICES];
    wire signed [OPW-1:0]    op_y2 [dpa_pkg::SLICES];
    wire                     sub_req [dpa_pkg::SLICES];

    // ----------------------------------------------------------------
    // register bus decode
    // ----------------------------------------------------------------
    // one wait cycle: read data is captured while waitrequest is high
    assign bus_req         = avs_read | avs_write;
    assign taking          = bus_req && phase_reg == dpa_pkg::PHASE_ANSWER;
    assign avs_waitrequest = bus_req && phase_reg == dpa_pkg::PHASE_IDLE;
    assign wr_take         = avs_write && taking && avs_byteenable[0];
    assign sel_ctrl        = avs_address == dpa_pkg::CTRL_OFFSET;
    assign sel_status      = avs_address == dpa_pkg::STATUS_OFFSET;
    assign sel_mask        = avs_address == dpa_pkg::MASK_OFFSET;
    assign sel_lo          = avs_address == dpa_pkg::RESULT_LO_OFFSET;
    assign sel_hi          = avs_address == dpa_pkg::RESULT_HI_OFFSET;
    assign result_wide     = {{(64-ACCW){result[ACCW-1]}}, result};
    assign read_mux        = sel_ctrl   ? {28'h000_0000, ctrl_reg}
                           : sel_status ? {31'h0000_0000, status_reg}
                           : sel_mask   ? {31'h0000_0000, mask_reg}
                           : sel_lo     ? result_wide[31:0]
                           : sel_hi     ? hi_shadow_reg
                           : 32'h0000_0000;
    assign avs_readdata    = readdata_reg;

    assign phase_next     = (phase_reg == dpa_pkg::PHASE_IDLE && bus_req)
                            ? dpa_pkg::PHASE_ANSWER : dpa_pkg::PHASE_IDLE;
    assign read_open      = avs_read && phase_reg == dpa_pkg::PHASE_IDLE;
    assign readdata_next  = read_open
                            ? read_mux : readdata_reg;
    // reading the low word freezes the high word so a 64-bit read is coherent
    assign hi_shadow_next = (read_open && sel_lo)
                            ? result_wide[63:32] : hi_shadow_reg;

    // ----------------------------------------------------------------
    // control, status and mask
    // ----------------------------------------------------------------
    assign ctrl_next   = (wr_take && sel_ctrl)
                         ? avs_writedata[dpa_pkg::CTRL_WIDTH-1:0] : ctrl_reg;
    assign clear_next  = wr_take && sel_ctrl && avs_writedata[dpa_pkg::CTRL_CLEAR_BIT];
    assign mask_next   = (wr_take && sel_mask) ? avs_writedata[0:0] : mask_reg;
    // a new overflow in the clearing cycle wins over the clear
    assign status_next = (status_reg & ~((wr_take && sel_status)
                         ? avs_writedata[dpa_pkg::STATUS_OVERFLOW_BIT +: 1] : 1'b0))
                         | ovf_set;
    assign irq         = |(status_reg & mask_reg);

    // ----------------------------------------------------------------
    // slices
    // ----------------------------------------------------------------
    assign acc_mode = ctrl_reg[dpa_pkg::CTRL_MODE_BIT]
                      == dpa_pkg::dual_product_accumulate_mode;
    assign op_x1    = '{s0_mult_one_x, s1_mult_one_x};
    assign op_y1    = '{s0_mult_one_y, s1_mult_one_y};
    assign op_x2    = '{s0_mult_two_x, s1_mult_two_x};
    assign op_y2    = '{s0_mult_two_y, s1_mult_two_y};
    // accumulate mode always adds the two products
    assign sub_req  = '{!acc_mode && s0_subtract, !acc_mode && s1_subtract};

    genvar s;
    generate
        for (s = 0; s < dpa_pkg::SLICES; s++)
        begin : g_slice
            product_pair_unit #(
                .OPW (OPW)
            ) u_pair (
                .clock       (clock),
                .rst_b       (rst_b),
                .in_reg_en   (ctrl_reg[dpa_pkg::CTRL_IN_REG_BIT]),
                .pipe_reg_en (ctrl_reg[dpa_pkg::CTRL_PIPE_REG_BIT]),
                .mult_one_x  (op_x1[s]),
                .mult_one_y  (op_y1[s]),
                .mult_two_x  (op_x2[s]),
                .mult_two_y  (op_y2[s]),
                .subtract    (sub_req[s]),
                .sum         (pp[s])
            );
            assign pp_ext[s] = {{(ACCW-PW){pp[s][PW-1]}}, pp[s]};
        end
    endgenerate

    // ----------------------------------------------------------------
    // accumulator and cascade adder
    // ----------------------------------------------------------------
    // cascade sum cannot leave the accumulator range, so it never flags overflow
    assign acc_sum     = result_reg + pp_ext[0];
    assign cascade_sum = pp_ext[0] + pp_ext[1];
    assign ovf_comb    = (result_reg[ACCW-1] == pp_ext[0][ACCW-1])
                         && (acc_sum[ACCW-1] != result_reg[ACCW-1]);
    assign ovf_set     = acc_mode && ovf_comb && !clear_reg;
    assign result_next = clear_reg ? '0 : acc_mode ? acc_sum : cascade_sum;
    assign overflow_next = ovf_set;
    // output stage is bypassable only in cascade mode
    assign out_bypass  = !acc_mode && !ctrl_reg[dpa_pkg::CTRL_OUT_REG_BIT];
    assign result      = out_bypass ? cascade_sum : result_reg;
    assign overflow    = overflow_reg;

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            phase_reg     <= dpa_pkg::PHASE_IDLE;
            ctrl_reg      <= dpa_pkg::CTRL_RESET;
            clear_reg     <= 1'b0;
            status_reg    <= dpa_pkg::STATUS_RESET;
            mask_reg      <= dpa_pkg::MASK_RESET;
            readdata_reg  <= 32'h0000_0000;
            hi_shadow_reg <= 32'h0000_0000;
        end
        else
        begin
            phase_reg     <= phase_next;
            ctrl_reg      <= ctrl_next;
            clear_reg     <= clear_next;
            status_reg    <= status_next;
            mask_reg      <= mask_next;
            readdata_reg  <= readdata_next;
            hi_shadow_reg <= hi_shadow_next;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            result_reg   <= '0;
            overflow_reg <= 1'b0;
        end
        else
        begin
            result_reg   <= result_next;
            overflow_reg <= overflow_next;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    accum_step_a: assert property (@(posedge clock) disable iff (!rst_b)
        $past(rst_b) && $past(acc_mode) && !$past(clear_reg) |->
        result_reg == $past(result_reg) + $past(pp_ext[0]))
        else $error("accumulator did not add both products to previous sum");

    out_always_a: assert property (@(posedge clock) disable iff (!rst_b)
        acc_mode |-> result == result_reg)
        else $error("output register bypassed in accumulate mode");

    clear_zero_a: assert property (@(posedge clock) disable iff (!rst_b)
        clear_reg ##1 1'b1 |-> result_reg == '0)
        else $error("accumulator not zeroed after clear");

    overflow_reg_a: assert property (@(posedge clock) disable iff (!rst_b)
        overflow |-> $past(acc_mode) && $past(ovf_comb))
        else $error("overflow flag without an accumulator overflow");

    overflow_sign_a: assert property (@(posedge clock) disable iff (!rst_b)
        $past(rst_b) && $past(acc_mode) && !$past(clear_reg)
        && $past(result_reg[ACCW-1]) && $past(pp_ext[0][ACCW-1])
        && !result_reg[ACCW-1] |-> overflow)
        else $error("negative wrap not flagged");

    cascade_sum_a: assert property (@(posedge clock) disable iff (!rst_b)
        out_bypass |-> result == pp_ext[0] + pp_ext[1])
        else $error("cascade output is not the sum of both slices");

    cascade_reg_a: assert property (@(posedge clock) disable iff (!rst_b)
        $past(rst_b) && !acc_mode && !out_bypass && !$past(acc_mode) && !$past(clear_reg)
        |-> result == $past(cascade_sum))
        else $error("registered cascade output not one cycle late");

    irq_level_a: assert property (@(posedge clock) disable iff (!rst_b)
        $past(rst_b) && $past(status_reg[0] && mask_reg[0])
        && !$past(wr_take && (sel_status || sel_mask)) |-> irq)
        else $error("interrupt dropped while unmasked status still set");

    bus_wait_a: assert property (@(posedge clock) disable iff (!rst_b)
        $rose(bus_req) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("bus answer not on second cycle");

    read_capture_a: assert property (@(posedge clock) disable iff (!rst_b)
        read_open |=> avs_readdata == $past(read_mux))
        else $error("read data not captured in the first request cycle");

    read_hold_a: assert property (@(posedge clock) disable iff (!rst_b)
        phase_reg == dpa_pkg::PHASE_ANSWER |=> $stable(avs_readdata))
        else $error("read data changed in the answer cycle");

    hi_snapshot_a: assert property (@(posedge clock) disable iff (!rst_b)
        read_open && sel_lo |=> hi_shadow_reg == $past(result_wide[63:32]))
        else $error("high word not frozen by low word read");

    ctrl_write_a: assert property (@(posedge clock) disable iff (!rst_b)
        wr_take && sel_ctrl |=> ctrl_reg == $past(avs_writedata[dpa_pkg::CTRL_WIDTH-1:0]))
        else $error("control write not applied");

    ctrl_hold_a: assert property (@(posedge clock) disable iff (!rst_b)
        !(wr_take && sel_ctrl) |=> $stable(ctrl_reg))
        else $error("control changed without a control write");

    mask_write_a: assert property (@(posedge clock) disable iff (!rst_b)
        wr_take && sel_mask |=> mask_reg[0] == $past(avs_writedata[0]))
        else $error("mask write not applied");

    status_hold_a: assert property (@(posedge clock) disable iff (!rst_b)
        status_reg[0] && !(wr_take && sel_status
        && avs_writedata[dpa_pkg::STATUS_OVERFLOW_BIT]) |=> status_reg[0])
        else $error("overflow status lost without a clearing write");

    status_set_a: assert property (@(posedge clock) disable iff (!rst_b)
        ovf_set |=> status_reg[0] && overflow)
        else $error("overflow not registered in flag and status");

    clear_pulse_a: assert property (@(posedge clock) disable iff (!rst_b)
        clear_reg |=> !clear_reg)
        else $error("clear lasted more than one cycle");

    wrap_flag_a: assert property (@(posedge clock) disable iff (!rst_b)
        acc_mode && !clear_reg && ovf_comb |=> overflow)
        else $error("accumulator wrap not flagged");

endmodule

// ===== core/product_pair_unit.sv
// two multipliers with optional input and pipeline stages and an add/sub unit
`timescale 1ns/1ps
module product_pair_unit #(
    parameter int OPW = dpa_pkg::OPW_DEFAULT
) (
    // clock and reset
    input  wire logic                  clock,
    input  wire logic                  rst_b,
    // stage configuration
    input  wire logic                  in_reg_en,
    input  wire logic                  pipe_reg_en,
    // operands and select
    input  wire logic signed [OPW-1:0] mult_one_x,
    input  wire logic signed [OPW-1:0] mult_one_y,
    input  wire logic signed [OPW-1:0] mult_two_x,
    input  wire logic signed [OPW-1:0] mult_two_y,
    input  wire logic                  subtract,
    // result
    output logic signed [2*OPW:0]      sum
);
    // ----------------------------------------------------------------
    // input stage
    // ----------------------------------------------------------------
    // the select travels with the operands so a change stays aligned
    logic signed [OPW-1:0]   ox_reg [2];
    logic signed [OPW-1:0]   oy_reg [2];
    logic                    sub_in_reg;
    logic signed [OPW-1:0]   ox [2];
    logic signed [OPW-1:0]   oy [2];
    logic                    sub_in;
    logic signed [2*OPW-1:0] prod_reg [2];
    logic                    sub_pipe_reg;
    logic signed [2*OPW-1:0] prod_comb [2];
    logic signed [2*OPW-1:0] prod [2];
    logic                    sub_sel;

    assign ox[0]  = in_reg_en ? ox_reg[0] : mult_one_x;
    assign oy[0]  = in_reg_en ? oy_reg[0] : mult_one_y;
    assign ox[1]  = in_reg_en ? ox_reg[1] : mult_two_x;
    assign oy[1]  = in_reg_en ? oy_reg[1] : mult_two_y;
    assign sub_in = in_reg_en ? sub_in_reg : subtract;

    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            ox_reg     <= '{default: '0};
            oy_reg     <= '{default: '0};
            sub_in_reg <= 1'b0;
        end
        else
        begin
            ox_reg     <= '{mult_one_x, mult_two_x};
            oy_reg     <= '{mult_one_y, mult_two_y};
            sub_in_reg <= subtract;
        end
    end

    // ----------------------------------------------------------------
    // multipliers and pipeline stage
    // ----------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < 2; i++)
        begin : g_mult
            assign prod_comb[i] = ox[i] * oy[i];
            assign prod[i]      = pipe_reg_en ? prod_reg[i] : prod_comb[i];
        end
    endgenerate

    assign sub_sel = pipe_reg_en ? sub_pipe_reg : sub_in;

    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            prod_reg     <= '{default: '0};
            sub_pipe_reg <= 1'b0;
        end
        else
        begin
            prod_reg     <= prod_comb;
            sub_pipe_reg <= sub_in;
        end
    end

    // ----------------------------------------------------------------
    // add or subtract of the two products
    // ----------------------------------------------------------------
    assign sum = sub_sel ? (2*OPW+1)'(prod[0]) - (2*OPW+1)'(prod[1])
                         : (2*OPW+1)'(prod[0]) + (2*OPW+1)'(prod[1]);

    add_sub_flat_a: assert property (@(posedge clock) disable iff (!rst_b)
        !in_reg_en && !pipe_reg_en && subtract |->
        sum == (2*OPW+1)'(mult_one_x) * (2*OPW+1)'(mult_one_y)
               - (2*OPW+1)'(mult_two_x) * (2*OPW+1)'(mult_two_y))
        else $error("difference of products wrong with stages bypassed");

    input_stage_a: assert property (@(posedge clock) disable iff (!rst_b)
        in_reg_en && $past(rst_b) |->
        ox[0] == $past(mult_one_x) && oy[1] == $past(mult_two_y))
        else $error("input stage does not delay operands by one cycle");

endmodule

// ===== verif/fabric_operand_source.sv
// fabric-side model: one flop stage of user logic feeding the slice pair
`timescale 1ns/1ps
module fabric_operand_source #(
    parameter int OPW = 8
) (
    // clock
    input  wire logic                clock,
    // operand set from the bench
    input  wire logic [7:0][OPW-1:0] ops_next,
    input  wire logic [1:0]          sub_next,
    // operand set towards the slices
    output logic [7:0][OPW-1:0]      ops_reg = '0,
    output logic [1:0]               sub_reg = 2'h0
);
    // ----------------------------------------------------------------
    // operand stage
    // ----------------------------------------------------------------
    // the select shares the operands' flop, so it can never lead or lag them
    always_ff @(posedge clock)
    begin
        ops_reg <= ops_next;
        sub_reg <= sub_next;
    end
endmodule

// ===== verif/testbench.sv
// self-checking bench for the dual product accumulate slice pair
`timescale 1ns/1ps
module testbench;
    localparam int OPW  = 8;
    localparam int ACCW = 19;
    typedef struct { int op[8]; logic [1:0] sub; int exp; } row_t;
    logic                   clock         = 1'b0;
    logic                   rst_b         = 1'b0;
    logic [4:0]             avs_address   = 5'h00;
    logic                   avs_read      = 1'b0;
    logic                   avs_write     = 1'b0;
    logic [31:0]            avs_writedata = 32'h0000_0000;
    logic [31:0]            avs_readdata;
    logic                   avs_waitrequest;
    logic                   irq;
    logic [7:0][OPW-1:0]    ops_next      = '0;
    logic [1:0]             sub_next      = 2'h0;
    logic [7:0][OPW-1:0]    ops_reg;
    logic [1:0]             sub_reg;
    logic signed [ACCW-1:0] result;
    logic                   overflow;
    logic [31:0]            rd;
    logic signed [ACCW-1:0] acc_w;
    int                     bad_count     = 0;
    int                     num_checks    = 0;
    // rows 0..4 cascade cases; 5 full-scale step; 6 unit step
    row_t rows[7] = '{'{'{3, 5, 2, 7, -4, 6, 1, -8}, 2'b00, -3},
                      '{'{3, 5, 2, 7, -4, 6, 1, -8}, 2'b01, -31},
                      '{'{3, 5, 2, 7, -4, 6, 1, -8}, 2'b10, 13},
                      '{'{3, 5, 2, 7, -4, 6, 1, -8}, 2'b11, -15},
                      '{'{-128, -128, -128, -128, -128, -128, -128, -128}, 2'b00, 65536},
                      '{'{-128, -128, -128, -128, 5, 5, 5, 5}, 2'b11, 0},
                      '{'{1, 1, 1, 1, 0, 0, 0, 0}, 2'b00, 2}};

    always #5 clock = ~clock;

    fabric_operand_source #(.OPW(OPW)) fabric (.clock(clock), .ops_next(ops_next),
        .sub_next(sub_next), .ops_reg(ops_reg), .sub_reg(sub_reg));

    dual_product_accumulate_slice #(.OPW(OPW), .ACCW(ACCW)) dut (
        .clock(clock), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
        .s0_mult_one_x(ops_reg[0]), .s0_mult_one_y(ops_reg[1]), .s0_mult_two_x(ops_reg[2]),
        .s0_mult_two_y(ops_reg[3]), .s0_subtract(sub_reg[0]), .s1_mult_one_x(ops_reg[4]),
        .s1_mult_one_y(ops_reg[5]), .s1_mult_two_x(ops_reg[6]), .s1_mult_two_y(ops_reg[7]),
        .s1_subtract(sub_reg[1]), .result(result), .overflow(overflow));

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do
        begin
            @(posedge clock);
        end
        while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    // operands live for one cycle at the slice inputs, then zero
    task automatic drive(input row_t r);
        @(posedge clock);
        for (int i = 0; i < 8; i++)
            ops_next[i] <= OPW'(r.op[i]);
        sub_next <= r.sub;
        @(posedge clock);
        ops_next <= '0;
        sub_next <= 2'h0;
        #1;
    endtask

    // ----------------------------------------------------------------
    // sequence
    // ----------------------------------------------------------------
    initial
    begin
        repeat (5) @(posedge clock);
        rst_b <= 1'b1;
        #1;
        check("result", result, 32'h0000_0000);
        check("overflow", overflow, 32'h0000_0000);
        check("irq", irq, 32'h0000_0000);
        bus(1'b0, dpa_pkg::CTRL_OFFSET, 32'h0000_0000);
        check("ctrl", rd, 32'(dpa_pkg::CTRL_RESET));
        bus(1'b0, dpa_pkg::STATUS_OFFSET, 32'h0000_0000);
        check("status", rd, 32'(dpa_pkg::STATUS_RESET));
        bus(1'b0, dpa_pkg::MASK_OFFSET, 32'h0000_0000);
        check("mask", rd, 32'(dpa_pkg::MASK_RESET));
        bus(1'b1, 5'h14, 32'hffff_ffff);
        bus(1'b0, 5'h14, 32'h0000_0000);
        check("unmapped", rd, 32'h0000_0000);
        bus(1'b1, dpa_pkg::CTRL_OFFSET, 32'h0000_0001);
        for (int k = 0; k < 5; k++)
        begin
            drive(rows[k]);
            check("cascade", result, rows[k].exp);
        end
        // awkward cases: output stage, accumulate wrap, interrupt, stage latency
        bus(1'b1, dpa_pkg::CTRL_OFFSET, 32'h0000_0009);
        drive(rows[0]);
        check("out stage early", result, 32'h0000_0000);
        @(posedge clock);
        #1;
        check("out stage", result, 32'hffff_fffd);
        bus(1'b1, dpa_pkg::CTRL_OFFSET, 32'h0000_0010);
        @(posedge clock);
        #1;
        acc_w = '0;
        check("cleared", result, 32'h0000_0000);
        for (int i = 1; i <= 8; i++)
        begin
            drive(rows[5]);
            check("held", result, 32'(acc_w));
            @(posedge clock);
            #1;
            acc_w = acc_w + 19'sh0_8000;
            check("accumulate", result, 32'(acc_w));
            check("overflow", overflow, 32'(i == 8));
        end
        @(posedge clock);
        #1;
        check("overflow drop", overflow, 32'h0000_0000);
        check("irq masked", irq, 32'h0000_0000);
        bus(1'b0, dpa_pkg::RESULT_LO_OFFSET, 32'h0000_0000);
        check("result lo", rd, 32'hfffc_0000);
        bus(1'b0, dpa_pkg::RESULT_HI_OFFSET, 32'h0000_0000);
        check("result hi", rd, 32'hffff_ffff);
        bus(1'b0, dpa_pkg::STATUS_OFFSET, 32'h0000_0000);
        check("status set", rd, 32'h0000_0001);
        bus(1'b1, dpa_pkg::MASK_OFFSET, 32'h0000_0001);
        #1;
        check("irq raised", irq, 32'h0000_0001);
        bus(1'b1, dpa_pkg::STATUS_OFFSET, 32'h0000_0001);
        #1;
        check("irq cleared", irq, 32'h0000_0000);
        bus(1'b1, dpa_pkg::CTRL_OFFSET, 32'h0000_0016);
        @(posedge clock);
        drive(rows[6]);
        repeat (2) @(posedge clock);
        #1;
        check("staged early", result, 32'h0000_0000);
        @(posedge clock);
        #1;
        check("staged", result, 32'h0000_0002);
        wrap_up();
    end

    // a hang counts as one mismatch and ends the run through wrap_up, so it always reports FAIL
    initial
    begin
        repeat (5000) @(posedge clock);
        bad_count++;
        wrap_up();
    end
endmodule
